// ===== core/alias_remap.sv
/*
  Per-receive-port address translation between the local serial host
  and the remote serializers: per-port register copies, alias decode,
  remap, forward over the control channel and acknowledge handling.
  Assumes the register port and transaction port come from the device's
  own serial slave logic on mclk_i, and the control channel is logic.
*/
`timescale 1ns/1ps
module alias_remap
  import alias_remap_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  // clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   reset_n_i,
  // register access from the local serial slave
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  input  wire logic [7:0]             reg_wdata_i,
  output logic [7:0]                  reg_rdata_o,
  output logic                        reg_rvalid_o,
  // targets of slots 0..2, held by the neighbouring register bank
  input  wire logic [ADDR_W-1:0]      ext_target_i  [NUM_PORTS][NUM_ALIAS],
  // targets of slots 6..7 for the neighbouring alias decoders
  output logic [ADDR_W-1:0]           held_target_o [NUM_PORTS][NUM_HELD],
  // local transaction address phase
  input  wire logic                   txn_valid_i,
  input  wire txn_t                   txn_i,
  output logic                        txn_busy_o,
  output logic                        host_ack_valid_o,
  output logic                        host_ack_o,
  // control channel
  input  wire logic [NUM_PORTS-1:0]   fwd_lock_i,
  output logic                        fwd_valid_o,
  output fwd_t                        fwd_o,
  input  wire logic                   remote_ack_valid_i,
  input  wire logic                   remote_ack_i
);

  localparam int PORT_SEL_W = PORT_SEL_HI - PORT_SEL_LO + 1;

  logic [PORT_W-1:0] port_sel_reg;
  logic [ADDR_W-1:0] target_reg [NUM_PORTS][NUM_HELD];
  logic [7:0]        alias_reg  [NUM_PORTS][NUM_ALIAS];
  fwd_state_t        state_reg;
  logic              auto_done_reg;

  // register writes
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_sel_reg <= PORT_SEL_RST;
    end else if (reg_wr_i && reg_addr_i == PORT_SEL_OFS) begin
      port_sel_reg <= PORT_W'(reg_wdata_i[PORT_SEL_HI:PORT_SEL_LO]);
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int h = 0; h < NUM_HELD; h++) begin
          target_reg[p][h] <= TARGET_RST;
        end
        for (int a = 0; a < NUM_ALIAS; a++) begin
          alias_reg[p][a] <= ALIAS_RST;
        end
      end
    end else if (reg_wr_i) begin
      // only the copy of the selected port is touched
      unique case (reg_addr_i)
        TARGET6_OFS: target_reg[port_sel_reg][0] <= reg_wdata_i[ADDR_FIELD_HI:ADDR_FIELD_LO];
        TARGET7_OFS: target_reg[port_sel_reg][1] <= reg_wdata_i[ADDR_FIELD_HI:ADDR_FIELD_LO];
        ALIAS0_OFS:  alias_reg[port_sel_reg][0]  <= reg_wdata_i;
        ALIAS1_OFS:  alias_reg[port_sel_reg][1]  <= reg_wdata_i;
        ALIAS2_OFS:  alias_reg[port_sel_reg][2]  <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // register reads, one cycle after the strobe
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o  <= UNMAPPED_RD;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          PORT_SEL_OFS: reg_rdata_o <= {{(8 - PORT_SEL_W){1'b0}}, port_sel_reg};
          TARGET6_OFS:  reg_rdata_o <= {target_reg[port_sel_reg][0], 1'b0};
          TARGET7_OFS:  reg_rdata_o <= {target_reg[port_sel_reg][1], 1'b0};
          ALIAS0_OFS:   reg_rdata_o <= alias_reg[port_sel_reg][0];
          ALIAS1_OFS:   reg_rdata_o <= alias_reg[port_sel_reg][1];
          ALIAS2_OFS:   reg_rdata_o <= alias_reg[port_sel_reg][2];
          default:      reg_rdata_o <= UNMAPPED_RD;
        endcase
      end
    end
  end

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int h = 0; h < NUM_HELD; h++) begin
        held_target_o[p][h] = target_reg[p][h];
      end
    end
  end

  // alias decode on every port
  logic [NUM_PORTS-1:0] port_hit;
  logic [SLOT_W-1:0]    port_slot   [NUM_PORTS];
  logic [ADDR_W-1:0]    port_target [NUM_PORTS];
  logic [NUM_PORTS-1:0] port_auto;

  for (genvar gp = 0; gp < NUM_PORTS; gp++) begin : g_port
    alias_slot_match #(
      .SLOTS      (NUM_ALIAS)
    ) u_match (
      .addr_i     (txn_i.addr),
      .alias_i    (alias_reg[gp]),
      .target_i   (ext_target_i[gp]),
      .hit_o      (port_hit[gp]),
      .slot_o     (port_slot[gp]),
      .target_o   (port_target[gp]),
      .auto_ack_o (port_auto[gp])
    );
  end

  // lowest port wins if an alias is shared between ports
  logic              m_hit;
  logic [PORT_W-1:0] m_port;
  logic [SLOT_W-1:0] m_slot;
  logic [ADDR_W-1:0] m_target;
  logic              m_auto;
  logic              m_lock;

  always_comb begin
    m_hit    = 1'b0;
    m_port   = '0;
    m_slot   = '0;
    m_target = '0;
    m_auto   = 1'b0;
    m_lock   = 1'b0;
    for (int p = NUM_PORTS - 1; p >= 0; p--) begin
      if (port_hit[p]) begin
        m_hit    = 1'b1;
        m_port   = PORT_W'(p);
        m_slot   = port_slot[p];
        m_target = port_target[p];
        m_auto   = port_auto[p];
        m_lock   = fwd_lock_i[p];
      end
    end
  end

  logic accept;
  logic auto_write;
  logic do_fwd;

  assign accept     = (state_reg == ST_IDLE) && txn_valid_i;
  assign auto_write = m_auto && !txn_i.rnw;
  assign do_fwd     = m_hit && (m_lock || auto_write);
  assign txn_busy_o = (state_reg != ST_IDLE);

  // forward state
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg     <= ST_IDLE;
      auto_done_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (accept && do_fwd) begin
            state_reg     <= ST_WAIT;
            auto_done_reg <= auto_write;
          end
        end
        ST_WAIT: begin
          // limitation: no timeout; the channel must answer every frame
          if (remote_ack_valid_i) begin
            state_reg     <= ST_IDLE;
            auto_done_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // remapped frame toward the serializer
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fwd_valid_o <= 1'b0;
      fwd_o       <= '0;
    end else begin
      fwd_valid_o <= accept && do_fwd;
      if (accept && do_fwd) begin
        fwd_o.port <= m_port;
        fwd_o.slot <= m_slot;
        fwd_o.addr <= m_target;
        fwd_o.rnw  <= txn_i.rnw;
      end
    end
  end

  // acknowledge toward the local host
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_ack_valid_o <= 1'b0;
      host_ack_o       <= 1'b0;
    end else begin
      host_ack_valid_o <= 1'b0;
      if (accept && (!do_fwd || auto_write)) begin
        // unmatched or unlocked: refuse now; auto write: accept now
        host_ack_valid_o <= 1'b1;
        host_ack_o       <= do_fwd;
      end else if (state_reg == ST_WAIT && remote_ack_valid_i && !auto_done_reg) begin
        host_ack_valid_o <= 1'b1;
        host_ack_o       <= remote_ack_i;
      end
    end
  end

  // checks
  logic [7:0] m_alias;
  always_comb begin
    m_alias = alias_reg[m_port][m_slot];
  end

  chk_remap_addr: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    fwd_valid_o |-> fwd_o.addr == $past(m_target) && $past(accept) && $past(m_hit))
    else $error("forwarded address is not the remapped target");

  chk_fwd_follows: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    accept && m_hit && m_lock |=> fwd_valid_o && fwd_o.port == $past(m_port) ##1 !fwd_valid_o)
    else $error("matched locked transaction not forwarded once");

  chk_zero_alias: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    fwd_valid_o |-> $past(m_alias[ADDR_FIELD_HI:ADDR_FIELD_LO]) != '0)
    else $error("forwarded through a disabled slot");

  chk_alias_compare: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    fwd_valid_o |-> $past(txn_i.addr) == $past(m_alias[ADDR_FIELD_HI:ADDR_FIELD_LO]))
    else $error("forwarded address did not match its alias");

  chk_auto_ack: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    accept && m_hit && m_auto && !txn_i.rnw |=> host_ack_valid_o && host_ack_o && fwd_valid_o)
    else $error("auto acknowledged write not acknowledged");

  chk_auto_no_second: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_reg == ST_WAIT && auto_done_reg && remote_ack_valid_i |=> !host_ack_valid_o)
    else $error("remote answer leaked after auto acknowledge");

  chk_unlocked_nack: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    accept && !(m_hit && (m_lock || auto_write)) |=> host_ack_valid_o && !host_ack_o && !fwd_valid_o)
    else $error("refused transaction not answered with a nack");

  chk_port_copy: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    reg_wr_i && reg_addr_i == ALIAS0_OFS && port_sel_reg != PORT_W'(0)
      |=> $stable(alias_reg[0][0]) && alias_reg[$past(port_sel_reg)][0] == $past(reg_wdata_i))
    else $error("alias write reached the wrong port copy");

  chk_auto_bit: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    reg_wr_i && reg_addr_i == ALIAS1_OFS
      |=> alias_reg[$past(port_sel_reg)][1][AUTO_ACK_BIT] == $past(reg_wdata_i[AUTO_ACK_BIT]))
    else $error("auto acknowledge bit not stored");

  chk_target_lsb: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    reg_rd_i && (reg_addr_i == TARGET6_OFS || reg_addr_i == TARGET7_OFS)
      |=> reg_rvalid_o && !reg_rdata_o[0])
    else $error("target register low bit reads nonzero");

  chk_read_answer: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    reg_rvalid_o == $past(reg_rd_i))
    else $error("read answer not one cycle after the strobe");

  chk_held_copy: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    reg_wr_i && reg_addr_i == TARGET6_OFS
      |=> held_target_o[$past(port_sel_reg)][0] == $past(reg_wdata_i[ADDR_FIELD_HI:ADDR_FIELD_LO]))
    else $error("target write missed its port copy");

  chk_busy_frame: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    fwd_valid_o |-> txn_busy_o)
    else $error("frame forwarded without holding the host");

  chk_busy_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_reg == ST_WAIT && !remote_ack_valid_i |=> txn_busy_o)
    else $error("busy dropped before the remote answer");

  chk_remote_answer: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_reg == ST_WAIT && remote_ack_valid_i && !auto_done_reg
      |=> host_ack_valid_o && host_ack_o == $past(remote_ack_i))
    else $error("remote answer not passed to the host");

  cov_auto_write: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    accept && m_hit && auto_write && !m_lock);
  cov_remote_read: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    accept && m_hit && txn_i.rnw ##1 fwd_valid_o ##[1:20] host_ack_valid_o && host_ack_o);
  cov_unmatched: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    accept && !m_hit);
  cov_remote_nack: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_reg == ST_WAIT && remote_ack_valid_i && !remote_ack_i && !auto_done_reg);

endmodule

// ===== core/alias_remap_pkg.sv
/*
  Shared constants and carriers for the remote address remap block:
  register offsets, field layout, reset values, state codes, structs.
  Assumes an 8-bit register address space inside the device.
*/
package alias_remap_pkg;

  localparam int NUM_ALIAS   = 3;
  localparam int NUM_HELD    = 2;
  localparam int ADDR_W      = 7;
  localparam int PORT_W      = 2;
  localparam int SLOT_W      = 2;

  // register offsets
  localparam logic [7:0] PORT_SEL_OFS   = 8'h4C;
  localparam logic [7:0] TARGET6_OFS    = 8'h63;
  localparam logic [7:0] TARGET7_OFS    = 8'h64;
  localparam logic [7:0] ALIAS0_OFS     = 8'h65;
  localparam logic [7:0] ALIAS1_OFS     = 8'h66;
  localparam logic [7:0] ALIAS2_OFS     = 8'h67;

  // field layout
  localparam int ADDR_FIELD_HI  = 7;
  localparam int ADDR_FIELD_LO  = 1;
  localparam int AUTO_ACK_BIT   = 0;
  localparam int PORT_SEL_HI    = 1;
  localparam int PORT_SEL_LO    = 0;

  // reset values
  localparam logic [7:0]        ALIAS_RST    = 8'h00;
  localparam logic [ADDR_W-1:0] TARGET_RST   = 7'h00;
  localparam logic [PORT_W-1:0] PORT_SEL_RST = 2'h0;
  localparam logic [7:0]        UNMAPPED_RD  = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } fwd_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rnw;
  } txn_t;

  typedef struct packed {
    logic [PORT_W-1:0] port;
    logic [SLOT_W-1:0] slot;
    logic [ADDR_W-1:0] addr;
    logic              rnw;
  } fwd_t;

endpackage

// ===== core/alias_slot_match.sv
/*
  Combinational alias decoder for one receive port: compares a local
  target address with each alias slot and returns the remapped target.
  Assumes alias and target values come from flops on the same clock.
*/
`timescale 1ns/1ps
module alias_slot_match
  import alias_remap_pkg::*;
#(
  parameter int SLOTS = NUM_ALIAS
) (
  // lookup
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        alias_i  [SLOTS],
  input  wire logic [ADDR_W-1:0] target_i [SLOTS],
  // result
  output logic                   hit_o,
  output logic [SLOT_W-1:0]      slot_o,
  output logic [ADDR_W-1:0]      target_o,
  output logic                   auto_ack_o
);

  always_comb begin
    hit_o      = 1'b0;
    slot_o     = '0;
    target_o   = '0;
    auto_ack_o = 1'b0;
    // descending scan so the lowest slot wins on duplicate aliases
    for (int s = SLOTS - 1; s >= 0; s--) begin
      // a zero alias field never matches
      if (alias_i[s][ADDR_FIELD_HI:ADDR_FIELD_LO] != '0 &&
          alias_i[s][ADDR_FIELD_HI:ADDR_FIELD_LO] == addr_i) begin
        hit_o      = 1'b1;
        slot_o     = SLOT_W'(s);
        target_o   = target_i[s];
        auto_ack_o = alias_i[s][AUTO_ACK_BIT];
      end
    end
  end

endmodule

// ===== test/remote_ser_model.sv
/*
  Behavioural remote serializer on the control channel: takes each
  forwarded frame and answers after a bench-chosen delay with a
  bench-chosen acknowledge. Assumes the alias_remap clock and reset.
*/
`timescale 1ns/1ps
module remote_ser_model (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  // frame in, behaviour set by the bench
  input  wire logic       fwd_valid_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       ack_value_i,
  // answer out
  output logic            remote_ack_valid_o,
  output logic            remote_ack_o
);
  logic [3:0] cnt_reg;
  logic       pend_reg;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_reg           <= 1'b0;
      cnt_reg            <= 4'h0;
      remote_ack_valid_o <= 1'b0;
      remote_ack_o       <= 1'b0;
    end else begin
      remote_ack_valid_o <= 1'b0;
      // no kind idle level: the ack line toggles outside answers
      remote_ack_o       <= ~remote_ack_o;
      if (fwd_valid_i) begin
        pend_reg <= 1'b1;
        cnt_reg  <= delay_i;
      end else if (pend_reg) begin
        if (cnt_reg == 4'h0) begin
          pend_reg           <= 1'b0;
          remote_ack_valid_o <= 1'b1;
          remote_ack_o       <= ack_value_i;
        end else begin
          cnt_reg <= cnt_reg - 4'h1;
        end
      end
    end
  end
endmodule

// ===== test/testbench.sv
/*
  Self-checking bench for alias_remap: register copies per port, remap,
  forwarding and acknowledge paths. Assumes remote_ser_model on the
  control channel; expected results are queued and checked by a monitor.
*/
`timescale 1ns/1ps
module testbench
  import alias_remap_pkg::*;
();
  logic              mclk_i = 1'b0;
  logic              reset_n_i;
  logic [7:0]        reg_addr_i;
  logic              reg_wr_i;
  logic              reg_rd_i;
  logic [7:0]        reg_wdata_i;
  logic [7:0]        reg_rdata_o;
  logic              reg_rvalid_o;
  logic [ADDR_W-1:0] ext_t [4][NUM_ALIAS];
  logic [ADDR_W-1:0] held_t [4][NUM_HELD];
  logic              txn_valid_i;
  txn_t              txn_i;
  logic              txn_busy_o;
  logic              host_ack_valid_o;
  logic              host_ack_o;
  logic [3:0]        fwd_lock_i;
  logic              fwd_valid_o;
  fwd_t              fwd_o;
  logic              rack_v;
  logic              rack;
  logic [3:0]        ser_delay;
  logic              ser_ack;
  logic [31:0]       seed;
  logic [6:0]        a;
  logic [6:0]        b;
  logic [6:0]        d;
  logic [7:0]        rq [$];
  fwd_t              fq [$];
  logic              hq [$];
  int                fail_count = 0;
  int                n_tests = 0;

  always #50 mclk_i = ~mclk_i;

  alias_remap #(.NUM_PORTS(4)) dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .ext_target_i(ext_t), .held_target_o(held_t), .txn_valid_i(txn_valid_i),
    .txn_i(txn_i), .txn_busy_o(txn_busy_o), .host_ack_valid_o(host_ack_valid_o), .host_ack_o(host_ack_o),
    .fwd_lock_i(fwd_lock_i), .fwd_valid_o(fwd_valid_o), .fwd_o(fwd_o), .remote_ack_valid_i(rack_v),
    .remote_ack_i(rack));

  remote_ser_model ser_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .fwd_valid_i(fwd_valid_o),
    .delay_i(ser_delay), .ack_value_i(ser_ack), .remote_ack_valid_o(rack_v), .remote_ack_o(rack));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(negedge mclk_i);
    reg_addr_i = ad;
    reg_wdata_i = dt;
    reg_wr_i = 1'b1;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    rq.push_back(e);
    @(negedge mclk_i);
    reg_addr_i = ad;
    reg_rd_i = 1'b1;
    @(negedge mclk_i);
    reg_rd_i = 1'b0;
    @(negedge mclk_i);
  endtask

  // busy drops one cycle after the remote answer; bounded wait
  task automatic txn(input logic [6:0] ad, input logic r, input logic fon, input fwd_t fe,
                     input logic hon, input logic he);
    int i;
    i = 0;
    if (fon)
      fq.push_back(fe);
    if (hon)
      hq.push_back(he);
    @(negedge mclk_i);
    txn_i = txn_t'({ad, r});
    txn_valid_i = 1'b1;
    @(negedge mclk_i);
    txn_valid_i = 1'b0;
    check("txn_busy", {15'h0, txn_busy_o}, {15'h0, fon});
    while (txn_busy_o !== 1'b0) begin
      if (i == 40) begin
        fail_count++;
        stop_test();
      end
      i++;
      @(negedge mclk_i);
    end
    repeat (2) @(negedge mclk_i);
  endtask

  always @(negedge mclk_i) begin
    if (reg_rvalid_o === 1'b1)
      check("reg_rdata", {8'h00, reg_rdata_o}, rq.size() ? {8'h00, rq.pop_front()} : 16'hdead);
    if (fwd_valid_o === 1'b1)
      check("fwd_frame", 16'(fwd_o), fq.size() ? 16'(fq.pop_front()) : 16'hffff);
    if (host_ack_valid_o === 1'b1)
      check("host_ack", {15'h0, host_ack_o}, hq.size() ? {15'h0, hq.pop_front()} : 16'h0002);
  end

  initial begin
    reset_n_i = 1'b0;
    {reg_addr_i, reg_wr_i, reg_rd_i, reg_wdata_i, txn_valid_i} = '0;
    txn_i = '0;
    fwd_lock_i = 4'h0;
    ser_delay = 4'h1;
    ser_ack = 1'b1;
    seed = 32'h1445_cea9;
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < NUM_ALIAS; s++) begin
        seed = xs(seed);
        ext_t[p][s] = seed[6:0];
      end
    end
    seed = xs(seed);
    a = {1'b0, seed[5:1], 1'b1};
    b = {1'b1, seed[13:8]};
    d = a ^ 7'h04;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    reset_n_i = 1'b1;
    for (int o = 8'h63; o <= 8'h67; o++)
      rd(8'(o), 8'h00);
    rd(8'h4C, 8'h00);
    wr(8'h63, 8'hFF);
    rd(8'h63, 8'hFE);
    check("held_target", 16'(held_t[0][0]), 16'h007F);
    wr(8'h4C, 8'hFD);
    rd(8'h4C, 8'h01);
    rd(8'h63, 8'h00);
    rd(8'h70, 8'h00);
    wr(8'h64, {d, 1'b1});
    rd(8'h64, {d, 1'b0});
    check("held_target", 16'(held_t[1][1]), 16'(d));
    // targets of slots 0..2 are already present on ext_t
    wr(8'h65, {a, 1'b0});
    rd(8'h65, {a, 1'b0});
    fwd_lock_i = 4'b0010;
    txn(a, 1'b1, 1'b1, fwd_t'({2'd1, 2'd0, ext_t[1][0], 1'b1}), 1'b1, 1'b1);
    ser_delay = 4'h6;
    ser_ack = 1'b0;
    txn(a, 1'b0, 1'b1, fwd_t'({2'd1, 2'd0, ext_t[1][0], 1'b0}), 1'b1, 1'b0);
    txn(7'h00, 1'b1, 1'b0, '0, 1'b1, 1'b0);
    txn(a ^ 7'h02, 1'b1, 1'b0, '0, 1'b1, 1'b0);
    wr(8'h67, {b, 1'b1});
    rd(8'h67, {b, 1'b1});
    fwd_lock_i = 4'b0000;
    txn(b, 1'b0, 1'b1, fwd_t'({2'd1, 2'd2, ext_t[1][2], 1'b0}), 1'b1, 1'b1);
    txn(b, 1'b1, 1'b0, '0, 1'b1, 1'b0);
    wr(8'h65, 8'h00);
    txn(a, 1'b1, 1'b0, '0, 1'b1, 1'b0);
    wr(8'h4C, 8'h00);
    wr(8'h66, {d, 1'b0});
    fwd_lock_i = 4'b1111;
    ser_delay = 4'h0;
    ser_ack = 1'b1;
    txn(d, 1'b1, 1'b1, fwd_t'({2'd0, 2'd1, ext_t[0][1], 1'b1}), 1'b1, 1'b1);
    repeat (4) @(negedge mclk_i);
    // mid-run reset: every copy and the port select return to zero
    reset_n_i = 1'b0;
    @(negedge mclk_i);
    reset_n_i = 1'b1;
    rd(8'h66, 8'h00);
    rd(8'h4C, 8'h00);
    check("queues_left", 16'(rq.size() + fq.size() + hq.size()), 16'h0000);
    stop_test();
  end
endmodule
